//--- rtl/spr_pkg.sv
// Notes on behaviour
// - unlock write, then sleep-off write within four cycles
// - sleep-off bit becomes active three cycles later
// - sleep-off bit clears itself after three cycles
// - detector off only if sleeping while active
// - sleep entered only with sleep arm set
// - mode field: idle, noise reduction, power-down, standby
// - sleep-off bit settable only through unlock bit
// - variants without feature read both bits zero
// - upper four gating bits read zero
// - bit 3 freezes timer one, resumes intact
// - bit 2 freezes timer zero, resumes intact
// - bit 1 stops serial clock, software reinitialises
// - comparator unusable while converter gated
// - deep sleep disables input buffers except wakeup
// - input disable register bit turns buffer off
// - enabled watchdog keeps running in all sleep
// - reset loads initial values, start at vector
// - ports forced to initial state immediately on reset
// - internal reset stretched by fuse-selected delay
// - gated peripheral frozen, its registers blocked
package spr_pkg;
  localparam logic [3:0] SPR_ADR_PMC  = 4'h0;
  localparam logic [3:0] SPR_ADR_PCG  = 4'h4;
  localparam logic [3:0] SPR_ADR_DID  = 4'h8;
  localparam logic [3:0] SPR_ADR_STAT = 4'hC;
  localparam int SPR_B_SOFF   = 7;
  localparam int SPR_B_ARM    = 5;
  localparam int SPR_B_MODE_H = 4;
  localparam int SPR_B_MODE_L = 3;
  localparam int SPR_B_UNLK   = 2;
  localparam int SPR_B_T1     = 3;
  localparam int SPR_B_T0     = 2;
  localparam int SPR_B_SER    = 1;
  localparam int SPR_B_ADC    = 0;
  localparam logic [7:0] SPR_PMC_RST = 8'h00;
  localparam logic [7:0] SPR_PCG_RST = 8'h00;
  localparam logic [7:0] SPR_PCG_MSK = 8'h0F;
  localparam logic [7:0] SPR_DID_RST = 8'h00;
  localparam logic [2:0] SPR_UNLK_WIN = 3'h4;
  localparam logic [1:0] SPR_SOFF_LIFE = 2'h3;
  typedef enum logic [1:0] {
    SPR_IDLE    = 2'b00,
    SPR_ADCNR   = 2'b01,
    SPR_PWRDOWN = 2'b10,
    SPR_STANDBY = 2'b11
  } spr_mode_type;
  typedef enum logic [1:0] {
    SPR_RUN   = 2'b00,
    SPR_SLEEP = 2'b01,
    SPR_HOLD  = 2'b10
  } spr_state_type;
endpackage

//--- rtl/spr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module spr_ctrl #(
  parameter bit          HAS_BOD_OFF = 1'b1,
  parameter logic [15:0] DLY_FAST    = 16'h0010,
  parameter logic [15:0] DLY_MID     = 16'h0400,
  parameter logic [15:0] DLY_SLOW    = 16'h2000,
  parameter logic [15:0] DLY_LONG    = 16'h4000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        ext_rst_i,
  input  wire logic        wdt_rst_i,
  input  wire logic        bod_rst_i,
  input  wire logic [1:0]  startup_time_fuses_i,
  input  wire logic [3:0]  clock_select_fuses_i,
  input  wire logic        wdt_enabled_i,
  input  wire logic        sleep_instr_i,
  input  wire logic        wake_i,
  input  wire logic [7:0]  wake_pin_mask_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             sleeping_o,
  output logic [1:0]       sleep_mode_o,
  output logic             cpu_clk_en_o,
  output logic             io_clk_en_o,
  output logic             adc_clk_en_o,
  output logic             timer_one_clk_en_o,
  output logic             timer_zero_clk_en_o,
  output logic             serial_clk_en_o,
  output logic             converter_clk_en_o,
  output logic             comparator_usable_o,
  output logic             gated_access_block_o,
  output logic [7:0]       input_buf_en_o,
  output logic             brownout_detector_en_o,
  output logic             wdt_run_o,
  output logic             port_reset_o,
  output logic             internal_reset_o,
  output logic             reset_vector_o
);
  // state kept by this block:
  // control byte with sleep arm, mode field and the two guarded bits
  // clock gating byte, only the low nibble is storage
  // input disable byte, one bit per pin buffer
  // unlock window down-counter and age of the sleep-off bit
  // one-cycle active pulse of the sleep-off bit
  // latched detector switch-off for the current sleep period
  // registered bus answer and read data
  // sleep / stretch state and the stretch down-counter
  // everything here is reset by any reset source; the stretch counter loads its fuse length

  logic [7:0] pmc_r, pmc_nxt;
  logic [7:0] pcg_r, pcg_nxt;
  logic [7:0] did_r, did_nxt;
  logic [2:0] unlk_r, unlk_nxt;
  logic [1:0] soff_age_r, soff_age_nxt;
  logic       soff_act_r, soff_act_nxt;
  logic       bod_off_r, bod_off_nxt;
  logic       ack_r, ack_nxt;
  logic       err_r, err_nxt;
  logic [31:0] dat_r, dat_nxt;
  spr_pkg::spr_state_type st_r, st_nxt;
  logic [15:0] dly_r, dly_nxt;
  logic        hold_r, hold_nxt;
  logic        vec_r, vec_nxt;
  logic        any_rst;
  logic        req;
  logic        wr_pmc;
  logic        deep;
  spr_pkg::spr_mode_type mode;

  // address decode shared by read and write paths
  function automatic logic [1:0] spr_dec(input logic [3:0] a);
    if (a == spr_pkg::SPR_ADR_PMC) begin
      spr_dec = 2'h0;
    end else if (a == spr_pkg::SPR_ADR_PCG) begin
      spr_dec = 2'h1;
    end else if (a == spr_pkg::SPR_ADR_DID) begin
      spr_dec = 2'h2;
    end else begin
      spr_dec = 2'h3;
    end
  endfunction


  // stretch length picked from the two fuse groups
  // the xor mapping is arbitrary; only the four lengths matter
  // fuses are sampled every reset cycle, so a late fuse change
  // still lands before the stretch starts counting

  // fuse selection of the stretch length
  function automatic logic [15:0] spr_dly(input logic [1:0] startup_time_fuses, input logic [3:0] cks);
    logic [1:0] s;
    s = startup_time_fuses ^ cks[1:0];
    case (s)
      2'h0:    spr_dly = DLY_FAST;
      2'h1:    spr_dly = DLY_MID;
      2'h2:    spr_dly = DLY_SLOW;
      default: spr_dly = DLY_LONG;
    endcase
  endfunction


  // all reset sources merged into one level
  // purely combinational so the port reset needs no clock edge;
  // the registered state still waits for the next edge
  // a glitch on any source resets the ports, by intent

  assign any_rst = rst_i | por_i | ext_rst_i | wdt_rst_i | bod_rst_i;
  assign req     = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
  assign wr_pmc  = req & wb_we_i & wb_sel_i[0] & (spr_dec(wb_adr_i) == 2'h0);
  assign mode    = spr_pkg::spr_mode_type'(pmc_r[spr_pkg::SPR_B_MODE_H:spr_pkg::SPR_B_MODE_L]);


  // timed unlock, in cycles of clk_i:
  // unlock write opens a window of four cycles
  // a set write inside the window sets the sleep-off bit
  // the bit reads one for three cycles, then clears itself
  // as it clears, the active pulse stands for one cycle
  // a sleep instruction sampled on that pulse in power-down or standby turns the detector off
  // a set write after the window closes is dropped silently
  // set wins over the self-clear when both fall in one cycle
  // trade-off: software sees no error for a late write,
  // it must read the bit back if it cares

  // register file, timed unlock and bus answer
  always_comb begin
    pmc_nxt      = pmc_r;
    pcg_nxt      = pcg_r;
    did_nxt      = did_r;
    unlk_nxt     = (unlk_r != 3'h0) ? unlk_r - 3'h1 : 3'h0;
    soff_age_nxt = soff_age_r;
    soff_act_nxt = soff_act_r;
    ack_nxt      = 1'b0;
    err_nxt      = 1'b0;
    dat_nxt      = dat_r;
    // bit self-clears; active three cycles after it is set
    if (pmc_r[spr_pkg::SPR_B_SOFF]) begin
      soff_age_nxt = soff_age_r + 2'h1;
      if (soff_age_r == spr_pkg::SPR_SOFF_LIFE - 2'h1) begin
        soff_act_nxt = 1'b1;
        pmc_nxt[spr_pkg::SPR_B_SOFF] = 1'b0;
        soff_age_nxt = 2'h0;
      end
    end else begin
      soff_act_nxt = 1'b0;
    end
    // one answer per request, one cycle after it is taken
    // unmapped addresses and status writes are refused with err
    // writes need the low byte lane; other lanes are ignored
    if (req) begin
      ack_nxt = (spr_dec(wb_adr_i) != 2'h3) || (wb_adr_i == spr_pkg::SPR_ADR_STAT && !wb_we_i);
      err_nxt = ~ack_nxt;
      if (wb_we_i && wb_sel_i[0]) begin
        if (spr_dec(wb_adr_i) == 2'h0) begin
          pmc_nxt[6:3] = wb_dat_i[6:3];
          pmc_nxt[1:0] = wb_dat_i[1:0];
          if (HAS_BOD_OFF) begin
            if (wb_dat_i[spr_pkg::SPR_B_SOFF] && wb_dat_i[spr_pkg::SPR_B_UNLK]) begin
              unlk_nxt = spr_pkg::SPR_UNLK_WIN;
            end else if (wb_dat_i[spr_pkg::SPR_B_SOFF] && unlk_r != 3'h0) begin
              pmc_nxt[spr_pkg::SPR_B_SOFF] = 1'b1;
              soff_age_nxt = 2'h0;
              unlk_nxt = 3'h0;
            end
            // a bare set with no open window is dropped
            pmc_nxt[spr_pkg::SPR_B_UNLK] = wb_dat_i[spr_pkg::SPR_B_UNLK];
          end
        end else if (spr_dec(wb_adr_i) == 2'h1) begin
          pcg_nxt = wb_dat_i[7:0] & spr_pkg::SPR_PCG_MSK;
        end else if (spr_dec(wb_adr_i) == 2'h2) begin
          did_nxt = wb_dat_i[7:0];
        end
      end
      if (!wb_we_i) begin
        if (spr_dec(wb_adr_i) == 2'h0) begin
          dat_nxt = {24'h000000, pmc_r};
        end else if (spr_dec(wb_adr_i) == 2'h1) begin
          dat_nxt = {24'h000000, pcg_r & spr_pkg::SPR_PCG_MSK};
        end else if (spr_dec(wb_adr_i) == 2'h2) begin
          dat_nxt = {24'h000000, did_r};
        end else begin
          dat_nxt = {27'h0000000, bod_off_r, soff_act_r, hold_r, st_r};
        end
      end
    end
    if (!HAS_BOD_OFF) begin
      pmc_nxt[spr_pkg::SPR_B_SOFF] = 1'b0;
      pmc_nxt[spr_pkg::SPR_B_UNLK] = 1'b0;
    end
  end


  // registers only; the next values come from the block above
  // any source, not just rst_i, clears the register group

  // all state of the register group; reset gives the initial values
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      pmc_r      <= spr_pkg::SPR_PMC_RST;
      pcg_r      <= spr_pkg::SPR_PCG_RST;
      did_r      <= spr_pkg::SPR_DID_RST;
      unlk_r     <= 3'h0;
      soff_age_r <= 2'h0;
      soff_act_r <= 1'b0;
      ack_r      <= 1'b0;
      err_r      <= 1'b0;
      dat_r      <= 32'h00000000;
    end else begin
      pmc_r      <= pmc_nxt;
      pcg_r      <= pcg_nxt;
      did_r      <= did_nxt;
      unlk_r     <= unlk_nxt;
      soff_age_r <= soff_age_nxt;
      soff_act_r <= soff_act_nxt;
      ack_r      <= ack_nxt;
      err_r      <= err_nxt;
      dat_r      <= dat_nxt;
    end
  end


  // hold: count the stretch down, then pulse the reset vector
  // run: enter sleep only with the arm bit set
  // sleep: leave on a wake event, detector switched back on
  // the detector switch-off is latched at sleep entry, so the
  // short active pulse of the sleep-off bit is enough
  // limitation: wake is taken at once; start-up delays live
  // outside this block

  // sleep and reset stretch state machine
  always_comb begin
    st_nxt      = st_r;
    dly_nxt     = dly_r;
    hold_nxt    = hold_r;
    vec_nxt     = 1'b0;
    bod_off_nxt = bod_off_r;
    case (st_r)
      spr_pkg::SPR_HOLD: begin
        if (dly_r == 16'h0000) begin
          hold_nxt = 1'b0;
          vec_nxt  = 1'b1;
          st_nxt   = spr_pkg::SPR_RUN;
        end else begin
          dly_nxt = dly_r - 16'h0001;
        end
      end
      spr_pkg::SPR_RUN: begin
        if (sleep_instr_i && pmc_r[spr_pkg::SPR_B_ARM]) begin
          st_nxt = spr_pkg::SPR_SLEEP;
          // only deep modes honour the detector switch-off
          bod_off_nxt = soff_act_r &&
                        (mode == spr_pkg::SPR_PWRDOWN || mode == spr_pkg::SPR_STANDBY);
        end
      end
      spr_pkg::SPR_SLEEP: begin
        if (wake_i) begin
          st_nxt      = spr_pkg::SPR_RUN;
          bod_off_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = spr_pkg::SPR_RUN;
      end
    endcase
  end


  // the stretch starts only after every source has gone low

  // stretch reloads each cycle while any source is active
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      st_r      <= spr_pkg::SPR_HOLD;
      dly_r     <= spr_dly(startup_time_fuses_i, clock_select_fuses_i);
      hold_r    <= 1'b1;
      vec_r     <= 1'b0;
      bod_off_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      dly_r     <= dly_nxt;
      hold_r    <= hold_nxt;
      vec_r     <= vec_nxt;
      bod_off_r <= bod_off_nxt;
    end
  end


  // clock domains while asleep:
  // idle stops only the cpu clock
  // noise reduction also stops the io clock
  // power-down and standby stop io and converter clocks,
  // which is what marks the deep modes for the input buffers
  // awake, every domain runs

  // clock domains per mode
  always_comb begin
    cpu_clk_en_o = ~sleeping_o;
    io_clk_en_o  = 1'b1;
    adc_clk_en_o = 1'b1;
    deep         = 1'b0;
    if (sleeping_o) begin
      case (mode)
        spr_pkg::SPR_IDLE: begin
          io_clk_en_o = 1'b1;
        end
        spr_pkg::SPR_ADCNR: begin
          io_clk_en_o = 1'b0;
        end
        default: begin
          // standby chosen without a crystal still behaves as power-down here
          io_clk_en_o  = 1'b0;
          adc_clk_en_o = 1'b0;
          deep         = 1'b1;
        end
      endcase
    end
  end

  assign sleeping_o   = (st_r == spr_pkg::SPR_SLEEP);
  assign sleep_mode_o = mode;


  // per-peripheral gating on top of the mode clocks
  // software must stop the converter itself before gating it;
  // this block does not check that
  // the access block flag lets the bus fabric refuse accesses
  // to any peripheral whose gating bit is set; mode clock stops do not raise it

  // gating leaves peripheral state intact, so clearing resumes it
  assign timer_one_clk_en_o  = io_clk_en_o & ~pcg_r[spr_pkg::SPR_B_T1];
  assign timer_zero_clk_en_o = io_clk_en_o & ~pcg_r[spr_pkg::SPR_B_T0];
  assign serial_clk_en_o     = io_clk_en_o & ~pcg_r[spr_pkg::SPR_B_SER];
  assign converter_clk_en_o  = adc_clk_en_o & ~pcg_r[spr_pkg::SPR_B_ADC];
  assign comparator_usable_o = ~pcg_r[spr_pkg::SPR_B_ADC];
  assign gated_access_block_o = |pcg_r[3:0];

  // wake pins stay live even in deep sleep
  assign input_buf_en_o = ~did_r & (deep ? wake_pin_mask_i : 8'hFF);


  // detector, watchdog and reset outputs
  // watchdog is passed through so sleep never stops it
  // internal reset covers both the sources and the stretch

  assign brownout_detector_en_o = ~bod_off_r;
  assign wdt_run_o        = wdt_enabled_i;
  assign port_reset_o     = any_rst;
  assign internal_reset_o = hold_r | any_rst;
  assign reset_vector_o   = vec_r;
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = dat_r;
endmodule
`default_nettype wire

//--- bench/spr_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module spr_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       por_i,
  input wire logic       ext_rst_i,
  input wire logic       wdt_rst_i,
  input wire logic       bod_rst_i,
  input wire logic       wdt_enabled_i,
  input wire logic       sleep_instr_i,
  input wire logic [7:0] wake_pin_mask_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       wb_err_o,
  input wire logic       sleeping_o,
  input wire logic [1:0] sleep_mode_o,
  input wire logic       converter_clk_en_o,
  input wire logic       comparator_usable_o,
  input wire logic [7:0] input_buf_en_o,
  input wire logic       brownout_detector_en_o,
  input wire logic       wdt_run_o,
  input wire logic       port_reset_o,
  input wire logic       internal_reset_o
);
  // one domain, so clock and disable are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no bus answer");
  a_unmapped_err: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o) else $error("unmapped not refused");
  a_port_reset_now: assert property ((por_i || ext_rst_i || wdt_rst_i || bod_rst_i)
    |-> port_reset_o) else $error("port reset late");
  a_reset_stretch: assert property ($fell(port_reset_o) |-> internal_reset_o[*8])
    else $error("internal reset not stretched");
  a_comparator_off: assert property (!converter_clk_en_o && !sleeping_o
    |-> !comparator_usable_o) else $error("comparator usable while gated");
  a_comparator_on: assert property (converter_clk_en_o |-> comparator_usable_o)
    else $error("comparator lost while running");
  a_deep_sleep_buf: assert property (sleeping_o && sleep_mode_o[1]
    |-> (input_buf_en_o & ~wake_pin_mask_i) == 8'h00) else $error("buffers on in sleep");
  a_watchdog_runs: assert property (wdt_enabled_i |-> wdt_run_o)
    else $error("watchdog stopped");
  a_sleep_needs_cmd: assert property ($rose(sleeping_o) |-> $past(sleep_instr_i))
    else $error("sleep without instruction");
  a_detector_off_sleep: assert property (!brownout_detector_en_o
    |-> sleep_mode_o[1] && (sleeping_o || $past(sleeping_o))) else $error("detector off awake");
  c_err: cover property (wb_err_o);
  c_sleep: cover property ($rose(sleeping_o));
  c_stretch_end: cover property ($fell(internal_reset_o));
  c_detector_off: cover property ($fell(brownout_detector_en_o));
endmodule
bind spr_ctrl spr_monitor u_mon (.clk_i, .rst_i, .por_i, .ext_rst_i, .wdt_rst_i, .bod_rst_i,
  .wdt_enabled_i, .sleep_instr_i, .wake_pin_mask_i, .wb_adr_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_err_o, .sleeping_o, .sleep_mode_o, .converter_clk_en_o, .comparator_usable_o,
  .input_buf_en_o, .brownout_detector_en_o, .wdt_run_o, .port_reset_o, .internal_reset_o);
`default_nettype wire

//--- bench/spr_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk_i, rst_i, sleep_instr_i, wake_i, wb_we_i, wb_cyc_i, wb_stb_i, e;
  logic [3:0]  src, wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        wb_ack_o, wb_err_o, sleeping_o, timer_one_clk_en_o, timer_zero_clk_en_o;
  logic        serial_clk_en_o, converter_clk_en_o, comparator_usable_o, port_reset_o;
  logic        brownout_detector_en_o, internal_reset_o, reset_vector_o;
  logic [1:0]  sleep_mode_o;
  logic [7:0]  input_buf_en_o;
  logic        cpu_clk_en_o, io_clk_en_o, adc_clk_en_o, gated_access_block_o, wdt_run_o, wdt_en;
  logic [1:0]  startup_time_fuses;
  logic [3:0]  cks, sel;
  logic [7:0]  wmask;
  int          failures, total_checks, n;
  // short stretch counts keep the reset scenarios quick
  spr_ctrl #(.DLY_FAST(16'h0010), .DLY_MID(16'h0014), .DLY_SLOW(16'h0018),
    .DLY_LONG(16'h001C)) dut (.clk_i, .rst_i, .por_i(src[0]), .ext_rst_i(src[1]),
    .wdt_rst_i(src[2]), .bod_rst_i(src[3]), .startup_time_fuses_i(startup_time_fuses),
    .clock_select_fuses_i(cks), .wdt_enabled_i(wdt_en), .sleep_instr_i, .wake_i,
    .wake_pin_mask_i(wmask), .wb_adr_i, .wb_dat_i, .wb_sel_i(sel), .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .sleeping_o, .sleep_mode_o, .cpu_clk_en_o,
    .io_clk_en_o, .adc_clk_en_o, .timer_one_clk_en_o, .timer_zero_clk_en_o,
    .serial_clk_en_o, .converter_clk_en_o, .comparator_usable_o, .gated_access_block_o,
    .input_buf_en_o, .brownout_detector_en_o, .wdt_run_o, .port_reset_o,
    .internal_reset_o, .reset_vector_o);
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one classic cycle; held until ack or err, then released
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 64);
    q = wb_dat_o;
    e = wb_err_o;
    if (k >= 64) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic sleep_try(input logic [7:0] ctl);
    bus(4'h0, 1'b1, {24'h0, ctl});
    @(posedge clk_i);
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    #1;
  endtask
  task automatic t_gating;
    for (int b = 0; b < 4; b++) begin
      bus(4'h4, 1'b1, 32'hF0 | (32'h1 << b));
      bus(4'h4, 1'b0, 32'h0);
      chk("gating", 32'h1 << b, q);
      chk("clk_en", {28'h0, ~(4'h1 << b)}, {timer_one_clk_en_o, timer_zero_clk_en_o,
        serial_clk_en_o, converter_clk_en_o});
      chk("comparator", 32'(b != 0), comparator_usable_o);
      chk("gated_block", 1, gated_access_block_o);
    end
    bus(4'h4, 1'b1, 32'h0);
    chk("gated_clear", 0, gated_access_block_o);
    @(posedge clk_i);
    wdt_en <= 1'b0;
    @(posedge clk_i);
    chk("wdt_off", 0, wdt_run_o);
    wdt_en <= 1'b1;
  endtask
  task automatic t_refused;
    bus(4'h2, 1'b0, 32'h0);
    chk("err_unmapped", 1, e);
    bus(4'hC, 1'b1, 32'h0);
    chk("err_status_wr", 1, e);
    bus(4'h0, 1'b1, 32'h80);
    bus(4'h0, 1'b0, 32'h0);
    chk("soff_locked", 0, q[7]);
    bus(4'h0, 1'b1, 32'h84);
    bus(4'h0, 1'b1, 32'h80);
    bus(4'h0, 1'b0, 32'h0);
    chk("soff_set", 1, q[7]);
    repeat (8) @(posedge clk_i);
    bus(4'h0, 1'b0, 32'h0);
    chk("soff_cleared", 0, q[7]);
    sel <= 4'hE;
    bus(4'h8, 1'b1, 32'hFF);
    sel <= 4'hF;
    bus(4'h8, 1'b0, 32'h0);
    chk("sel_masked", 0, q);
    bus(4'h8, 1'b1, 32'h0F);
    chk("buf_disable", 32'hF0, input_buf_en_o);
    bus(4'h8, 1'b1, 32'h0);
  endtask
  task automatic t_sleep;
    sleep_try(8'h10);
    chk("no_arm", 0, sleeping_o);
    for (int m = 0; m < 4; m++) begin
      sleep_try(8'h20 | 8'(m << 3));
      chk("asleep", 1, sleeping_o);
      chk("mode", m, sleep_mode_o);
      chk("detector", 1, brownout_detector_en_o);
      chk("clk_dom", {1'b0, m == 0, m < 2}, {cpu_clk_en_o, io_clk_en_o, adc_clk_en_o});
      chk("wdt_sleep", 1, wdt_run_o);
      if (m >= 2) chk("deep_buf", 32'h0C, input_buf_en_o);
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      n = 0;
      while (sleeping_o !== 1'b0 && n < 32) begin
        @(posedge clk_i);
        n++;
      end
      chk("woken", 0, sleeping_o);
    end
    // sleep sampled on the active pulse, three cycles after the set
    bus(4'h0, 1'b1, 32'hB4);
    bus(4'h0, 1'b1, 32'hB0);
    repeat (2) @(posedge clk_i);
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    #1;
    chk("detector_off", 0, brownout_detector_en_o);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    @(posedge clk_i);
    chk("detector_back", 1, brownout_detector_en_o);
  endtask
  // each of the four sources: ports reset with no edge, then fuse-set stretch
  task automatic t_resets;
    for (int i = 0; i < 4; i++) begin
      bus(4'h4, 1'b1, 32'h05);
      @(posedge clk_i);
      src <= 4'h1 << i;
      startup_time_fuses <= 2'(3 - i);
      cks <= 4'h3;
      #1;
      chk("port_reset", 1, port_reset_o);
      @(posedge clk_i);
      src <= 4'h0;
      n = 0;
      while (internal_reset_o === 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      chk("stretch", 18 + 4 * i, n);
      n = 0;
      while (reset_vector_o !== 1'b1 && n < 8) begin
        @(posedge clk_i);
        n++;
      end
      chk("vector", 1, reset_vector_o);
      bus(4'h4, 1'b0, 32'h0);
      chk("pcg_reset", 0, q);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end
  initial begin
    failures = 0;
    total_checks = 0;
    rst_i = 1'b1;
    src = 4'h0;
    startup_time_fuses = 2'h1;
    cks = 4'h2;
    sel = 4'hF;
    wmask = 8'h0C;
    wdt_en = 1'b1;
    sleep_instr_i = 1'b0;
    wake_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(4'h0, 1'b0, 32'h0);
    chk("ctl_reset", 0, q);
    t_gating();
    t_refused();
    t_sleep();
    t_resets();
    final_report();
  end
endmodule
`default_nettype wire
